// >>> fcsr_bus_cycle.v
// one asynchronous flash bus cycle (write or read) with fixed strobe width
`include "fcsr_map.vh"

module fcsr_bus_cycle #(
    parameter STROBE_CYC = (`FCSR_BUS_STROBE_NS + `FCSR_CLK_NS - 1) / `FCSR_CLK_NS
) (
    input wire clk,
    input wire rst,
    input wire start,
    input wire is_write,
    input wire [15:0] wdata,
    input wire [15:0] dq_in,
    output reg busy_q,
    output reg done_q,
    output reg [15:0] rdata_q,
    output reg ce_n_q,
    output reg oe_n_q,
    output reg we_n_q,
    output reg [15:0] dq_out_q,
    output reg dq_oe_q
);
    reg [7:0] cnt_q;
    reg wr_q;
    reg [15:0] dq_s1_q;
    reg [15:0] dq_s2_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dq_s1_q <= 16'h0000;
            dq_s2_q <= 16'h0000;
        end else begin
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= 16'h0000;
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            dq_out_q <= 16'h0000;
            dq_oe_q <= 1'b0;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (!busy_q) begin
                if (start) begin
                    busy_q <= 1'b1;
                    wr_q <= is_write;
                    ce_n_q <= 1'b0;
                    oe_n_q <= is_write;
                    we_n_q <= ~is_write;
                    dq_out_q <= wdata;
                    dq_oe_q <= is_write;
                    cnt_q <= 8'h00;
                end
            end else if (cnt_q < STROBE_CYC[7:0] + 8'h02) begin
                cnt_q <= cnt_q + 8'h01;
            end else begin
                // device latches on the rising strobe; oe high re-arms the status latch, ce high alone does not
                if (!wr_q) begin
                    rdata_q <= dq_s2_q;
                end
                ce_n_q <= 1'b1;
                oe_n_q <= 1'b1;
                we_n_q <= 1'b1;
                dq_oe_q <= 1'b0;
                busy_q <= 1'b0;
                done_q <= 1'b1;
            end
        end
    end
endmodule // fcsr_bus_cycle

// >>> fcsr_checker.sv
// concurrent checks on the flash-side pins of the host controller
module fcsr_checker #(
    parameter RESET_PULSE_CYC = 1000
) (
    input wire clk,
    input wire rst,
    input wire reset_powerdown_n_q,
    input wire chip_select_combo_n_q,
    input wire oe_n_q,
    input wire we_n_q,
    input wire [15:0] dq_out_q,
    input wire dq_oe_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    reg [10:0] low_cnt_q;
    // saturates so a long flash reset pulse cannot wrap the count
    always @(posedge clk or posedge rst) begin
        if (rst)
            low_cnt_q <= 11'h000;
        else if (reset_powerdown_n_q)
            low_cnt_q <= 11'h000;
        else if (low_cnt_q != 11'h7ff)
            low_cnt_q <= low_cnt_q + 11'h001;
    end
    a_pulse_width: assert property ($rose(reset_powerdown_n_q) |-> low_cnt_q >= RESET_PULSE_CYC)
        else $error("flash reset pulse too short");
    a_quiet_reset: assert property (!reset_powerdown_n_q |->
        chip_select_combo_n_q && oe_n_q && we_n_q && !dq_oe_q)
        else $error("bus active while flash held in reset");
    a_write_gap: assert property ($rose(reset_powerdown_n_q) |-> we_n_q [*8])
        else $error("write too soon after flash reset");
    a_no_clash: assert property (oe_n_q || we_n_q)
        else $error("read and write strobes low together");
    a_drive_dir: assert property (dq_oe_q |-> oe_n_q)
        else $error("host drives data during a read");
    a_code_low: assert property (!we_n_q |-> dq_oe_q && dq_out_q[15:8] == 8'h00)
        else $error("command not on low byte");
    a_read_width: assert property ($fell(oe_n_q) |-> !oe_n_q [*3])
        else $error("read strobe too short");
    a_write_width: assert property ($fell(we_n_q) |-> !we_n_q [*3])
        else $error("write strobe too short");
    a_sel_strobe: assert property ((!oe_n_q || !we_n_q) |-> !chip_select_combo_n_q)
        else $error("strobe without chip select");
endmodule // fcsr_checker

// >>> fcsr_flash_model.sv
// behavioural flash device: command decode, status latch, reset handling
module fcsr_flash_model (
    input wire clk,
    input wire reset_powerdown_n,
    input wire ce_n,
    input wire oe_n,
    input wire we_n,
    input wire [15:0] dq_h,
    input wire [7:0] fault,
    output logic [15:0] dq,
    output logic ready_busy_output
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] opst_q;
    logic [15:0] lat_q;
    logic [15:0] last_q;
    logic [15:0] wd_q;
    logic [4:0] cnt_q;
    logic stat_q;
    logic pend_q;
    logic we_q;
    logic oe_q;
    logic ce_q;
    assign ready_busy_output = reset_powerdown_n && cnt_q == 5'h00;
    // undriven bus inverts every clock, and holds its value only while reset_powerdown_n is low
    assign dq = (reset_powerdown_n && !ce_n && !oe_n) ? (stat_q ? lat_q : 16'h5a5a) : ~last_q;
    always @(posedge clk or negedge reset_powerdown_n) begin
        if (!reset_powerdown_n) begin
            opst_q <= 8'h80;
            stat_q <= 1'b0;
            pend_q <= 1'b0;
            cnt_q <= 5'h00;
            we_q <= 1'b1;
            oe_q <= 1'b1;
            ce_q <= 1'b1;
        end else begin
            we_q <= we_n;
            oe_q <= oe_n;
            ce_q <= ce_n;
            last_q <= dq;
            // data taken while the strobe is low; the host frees the bus as it raises it
            if (!we_n && !ce_n)
                wd_q <= dq_h;
            if (cnt_q != 5'h00)
                cnt_q <= cnt_q - 5'h01;
            if (cnt_q == 5'h01)
                opst_q <= (opst_q & 8'h3a) | 8'h80 | fault;
            if (oe_q && !oe_n && !ce_n)
                lat_q <= {8'h00, cnt_q != 5'h00 ? {1'b0, ~opst_q[6:0]} : opst_q};
            if (!we_q && we_n && !ce_q && cnt_q == 5'h00) begin
                if (pend_q) begin
                    pend_q <= 1'b0;
                    cnt_q <= 5'h10;
                    stat_q <= 1'b1;
                end else if (wd_q[7:0] == 8'hff)
                    stat_q <= 1'b0;
                else if (wd_q[7:0] == 8'h70)
                    stat_q <= 1'b1;
                else if (wd_q[7:0] == 8'h50) begin
                    stat_q <= 1'b1;
                    opst_q <= opst_q & 8'hc5;
                end else
                    pend_q <= 1'b1;
            end
        end
    end
endmodule // fcsr_flash_model

// >>> fcsr_host.v
// host controller: resets the flash, issues commands, polls the operation status
`include "fcsr_map.vh"

module fcsr_host #(
    parameter RESET_PULSE_CYC = (`FCSR_RESET_PULSE_MIN_NS + `FCSR_CLK_NS - 1) / `FCSR_CLK_NS,
    parameter WAKE_CYC = (`FCSR_WAKE_READ_DELAY_NS + `FCSR_CLK_NS - 1) / `FCSR_CLK_NS,
    parameter WRITE_WAIT_CYC = (`FCSR_RESET_TO_WRITE_NS + `FCSR_CLK_NS - 1) / `FCSR_CLK_NS
) (
    input wire clk,
    input wire rst,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [31:0] reg_rdata_q,
    output reg reset_powerdown_n_q,
    output reg chip_select_combo_n_q,
    output reg oe_n_q,
    output reg we_n_q,
    input wire [15:0] dq_in,
    output reg [15:0] dq_out_q,
    output reg dq_oe_q,
    input wire ready_busy_output
);
    localparam ST_RESET = 3'd0;
    localparam ST_WAKE = 3'd1;
    localparam ST_IDLE = 3'd2;
    localparam ST_SETUP = 3'd3;
    localparam ST_CONFIRM = 3'd4;
    localparam ST_POLL = 3'd5;

    reg [2:0] state_q;
    reg [15:0] cnt_q;
    reg [16:0] cmd_q;
    reg [7:0] opst_q;
    reg [15:0] data_q;
    reg auto_q;
    reg cmd_err_q;
    reg cyc_start;
    reg cyc_write;
    reg [15:0] cyc_wdata;
    reg rb_s1_q;
    reg rb_s2_q;
    wire cyc_busy;
    wire cyc_done;
    wire [15:0] cyc_rdata;
    wire cyc_ce_n;
    wire cyc_oe_n;
    wire cyc_we_n;
    wire [15:0] cyc_dq;
    wire cyc_dq_oe;
    wire ready = (state_q == ST_IDLE);
    wire two_cycle = cmd_q[`FCSR_CMD_TWO];

    fcsr_bus_cycle u_cycle (
        .clk(clk),
        .rst(rst),
        .start(cyc_start),
        .is_write(cyc_write),
        .wdata(cyc_wdata),
        .dq_in(dq_in),
        .busy_q(cyc_busy),
        .done_q(cyc_done),
        .rdata_q(cyc_rdata),
        .ce_n_q(cyc_ce_n),
        .oe_n_q(cyc_oe_n),
        .we_n_q(cyc_we_n),
        .dq_out_q(cyc_dq),
        .dq_oe_q(cyc_dq_oe)
    );

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rb_s1_q <= 1'b0;
            rb_s2_q <= 1'b0;
        end else begin
            rb_s1_q <= ready_busy_output;
            rb_s2_q <= rb_s1_q;
        end
    end

    // register pins so every output comes from a flip-flop; flash reset is held low in rst and in ST_RESET
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reset_powerdown_n_q <= 1'b0;
            chip_select_combo_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            dq_out_q <= 16'h0000;
            dq_oe_q <= 1'b0;
        end else begin
            reset_powerdown_n_q <= (state_q != ST_RESET);
            chip_select_combo_n_q <= cyc_ce_n;
            oe_n_q <= cyc_oe_n;
            we_n_q <= cyc_we_n;
            dq_out_q <= cyc_dq;
            dq_oe_q <= cyc_dq_oe;
        end
    end

    always @* begin
        cyc_start = 1'b0;
        cyc_write = 1'b1;
        cyc_wdata = 16'h0000;
        case (state_q)
            ST_SETUP: begin
                cyc_start = !cyc_busy && !cyc_done;
                cyc_wdata = {8'h00, cmd_q[7:0]};
            end
            ST_CONFIRM: begin
                cyc_start = !cyc_busy && !cyc_done;
                cyc_wdata = {8'h00, cmd_q[15:8]};
            end
            ST_POLL: begin
                cyc_start = !cyc_busy && !cyc_done && (cnt_q == 16'h0000);
                cyc_write = 1'b0;
            end
            default: begin
                cyc_start = 1'b0;
            end
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_RESET;
            cnt_q <= 16'h0000;
            cmd_q <= 17'h0_0000;
            opst_q <= `FCSR_OPST_RESET;
            data_q <= 16'h0000;
            auto_q <= 1'b1;
            cmd_err_q <= 1'b0;
        end else begin
            if (reg_write && reg_addr == `FCSR_REG_CTRL) begin
                auto_q <= reg_wdata[`FCSR_CTRL_AUTO];
            end
            case (state_q)
                ST_RESET: begin
                    if (cnt_q >= RESET_PULSE_CYC[15:0] - 16'h0001) begin
                        cnt_q <= 16'h0000;
                        state_q <= ST_WAKE;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_WAKE: begin
                    // both delays must pass and the flash must report ready
                    if (cnt_q >= WAKE_CYC[15:0] && cnt_q >= WRITE_WAIT_CYC[15:0]
                            && rb_s2_q) begin
                        state_q <= ST_IDLE;
                        opst_q <= `FCSR_OPST_RESET;
                    end else if (cnt_q != 16'hffff) begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_IDLE: begin
                    if (reg_write && reg_addr == `FCSR_REG_CTRL
                            && reg_wdata[`FCSR_CTRL_RESET]) begin
                        cnt_q <= 16'h0000;
                        state_q <= ST_RESET;
                    end else if (reg_write && reg_addr == `FCSR_REG_CMD) begin
                        cmd_q <= reg_wdata[16:0];
                        cmd_err_q <= 1'b0;
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (cyc_done) begin
                        if (two_cycle) begin
                            state_q <= ST_CONFIRM;
                        end else if (cmd_q[7:0] == `FCSR_CODE_READ_STATUS
                                || cmd_q[7:0] == `FCSR_CODE_CLEAR_STATUS) begin
                            cnt_q <= 16'h0000;
                            state_q <= ST_POLL;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_CONFIRM: begin
                    if (cyc_done) begin
                        cnt_q <= 16'h0000;
                        state_q <= auto_q ? ST_POLL : ST_IDLE;
                    end
                end
                ST_POLL: begin
                    // a fresh read cycle per sample; oe rises between reads
                    if (cyc_done) begin
                        data_q <= cyc_rdata;
                        opst_q <= cyc_rdata[7:0];
                        if (cyc_rdata[15:8] != 8'h00) begin
                            cmd_err_q <= 1'b1;
                        end
                        if (cyc_rdata[`FCSR_OPST_READY]) begin
                            state_q <= ST_IDLE;
                        end else begin
                            cnt_q <= 16'h0001;
                        end
                    end else if (cnt_q != 16'h0000) begin
                        cnt_q <= 16'h0000;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // read port; operation_status fields decoded for software
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_read) begin
            case (reg_addr)
                `FCSR_REG_CTRL: reg_rdata_q <= {30'h0000_0000, auto_q, 1'b0};
                `FCSR_REG_CMD: reg_rdata_q <= {15'h0000, cmd_q};
                `FCSR_REG_STAT: reg_rdata_q <= {16'h0000, 7'h00,
                    opst_q[`FCSR_OPST_ESUSP],
                    opst_q[`FCSR_OPST_PSUSP],
                    opst_q[`FCSR_OPST_VOLT_ERR],
                    opst_q[`FCSR_OPST_LOCK_ERR],
                    opst_q[`FCSR_OPST_ERASE_ERR:`FCSR_OPST_PROG_ERR],
                    cmd_err_q, rb_s2_q, ready};
                `FCSR_REG_OPST: reg_rdata_q <= {24'h00_0000, opst_q};
                `FCSR_REG_DATA: reg_rdata_q <= {16'h0000, data_q};
                default: reg_rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_q <= 32'h0000_0000;
        end
    end
endmodule // fcsr_host

// >>> fcsr_map.vh
// register map, command codes, status fields and timing for the flash host controller
`ifndef FCSR_MAP_VH
`define FCSR_MAP_VH

// host register offsets (word index)
`define FCSR_REG_CTRL 4'h0
`define FCSR_REG_CMD 4'h1
`define FCSR_REG_STAT 4'h2
`define FCSR_REG_OPST 4'h3
`define FCSR_REG_DATA 4'h4

// control register fields
`define FCSR_CTRL_RESET 0
`define FCSR_CTRL_AUTO 1

// command register fields: [7:0] setup code, [15:8] confirm code, [16] two-cycle flag
`define FCSR_CMD_TWO 16

// device command codes
`define FCSR_CODE_READ_ARRAY 8'hff
`define FCSR_CODE_READ_STATUS 8'h70
`define FCSR_CODE_CLEAR_STATUS 8'h50

// operation status bits
`define FCSR_OPST_RESET 8'h80
`define FCSR_OPST_READY 7
`define FCSR_OPST_ESUSP 6
`define FCSR_OPST_ERASE_ERR 5
`define FCSR_OPST_PROG_ERR 4
`define FCSR_OPST_VOLT_ERR 3
`define FCSR_OPST_PSUSP 2
`define FCSR_OPST_LOCK_ERR 1

// timing in ns
`define FCSR_CLK_NS 25
`define FCSR_RESET_PULSE_MIN_NS 25000
`define FCSR_WAKE_READ_DELAY_NS 210
`define FCSR_RESET_TO_WRITE_NS 210
`define FCSR_BUS_STROBE_NS 75

`endif

// >>> tb_top.sv
// self-checking bench for the flash host controller
`include "fcsr_map.vh"
`define CHK(a, b) begin \
    cmp_count++; \
    if ((a) !== (b)) begin \
        err_total++; \
        $display("mismatch at %0t: got %h want %h", $time, a, b); \
    end \
end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] fault = 8'h00;
    logic [31:0] rv;
    logic [7:0] tbl [7] = '{8'h10, 8'h20, 8'h30, 8'h08, 8'h02, 8'h40, 8'h04};
    wire [31:0] reg_rdata_q;
    wire reset_powerdown_n_q;
    wire chip_select_combo_n_q;
    wire oe_n_q;
    wire we_n_q;
    wire dq_oe_q;
    wire ready_busy_output;
    wire [15:0] dq_out_q;
    wire [15:0] flash_dq;
    wire [15:0] dq_w;
    int err_total = 0;
    int cmp_count = 0;
    assign dq_w = dq_oe_q ? dq_out_q : flash_dq;
    always #12.5 clk = ~clk;
    fcsr_host #(.RESET_PULSE_CYC(4)) uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata_q(reg_rdata_q), .reset_powerdown_n_q(reset_powerdown_n_q),
        .chip_select_combo_n_q(chip_select_combo_n_q), .oe_n_q(oe_n_q), .we_n_q(we_n_q),
        .dq_in(dq_w), .dq_out_q(dq_out_q), .dq_oe_q(dq_oe_q),
        .ready_busy_output(ready_busy_output));
    fcsr_flash_model u_flash (.clk(clk), .reset_powerdown_n(reset_powerdown_n_q),
        .ce_n(chip_select_combo_n_q), .oe_n(oe_n_q), .we_n(we_n_q), .dq_h(dq_w),
        .fault(fault), .dq(flash_dq), .ready_busy_output(ready_busy_output));
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 rv = reg_rdata_q;
    endtask
    task wait_idle;
        int n;
        n = 0;
        rd(`FCSR_REG_STAT);
        while (rv[0] !== 1'b1 && n < 3000) begin
            rd(`FCSR_REG_STAT);
            n++;
        end
        `CHK(rv[0], 1'b1)
    endtask
    task cmd(input logic [7:0] c, input logic two, input logic [7:0] cf);
        wr(`FCSR_REG_CMD, {15'h0000, two, cf, c});
        repeat (3) @(posedge clk);
        wait_idle;
    endtask
    task t_boot;
        wait_idle;
        rd(`FCSR_REG_OPST);
        `CHK(rv[7:0], 8'h80)
        rd(`FCSR_REG_STAT);
        `CHK(rv[1], 1'b1)
    endtask
    // each fault bit from 6 down to 1 and the 0x30 pair, then persistence and clearing of the error bits
    task t_faults;
        logic [7:0] f;
        for (int i = 0; i < 7; i++) begin
            f = tbl[i];
            fault <= f;
            cmd(8'h40, 1'b1, 8'hd0);
            rd(`FCSR_REG_OPST);
            `CHK(rv[7:0], 8'h80 | f)
            rd(`FCSR_REG_DATA);
            `CHK(rv[15:0], {8'h00, 8'h80 | f})
            rd(`FCSR_REG_STAT);
            `CHK(rv[8:2], {f[6], f[2], f[3], f[1], f[5:4], 1'b0})
            cmd(8'h70, 1'b0, 8'h00);
            rd(`FCSR_REG_OPST);
            `CHK(rv[7:0], 8'h80 | f)
            cmd(8'h50, 1'b0, 8'h00);
            rd(`FCSR_REG_OPST);
            `CHK(rv[7:0], 8'h80 | (f & 8'h44))
        end
    endtask
    task t_flash_reset;
        fault <= 8'h10;
        cmd(8'h40, 1'b1, 8'hd0);
        wr(`FCSR_REG_CTRL, 32'h0000_0003);
        repeat (3) @(posedge clk);
        wait_idle;
        cmd(8'h70, 1'b0, 8'h00);
        rd(`FCSR_REG_OPST);
        `CHK(rv[7:0], 8'h80)
    endtask
    // flash reset while an operation still runs, polling switched off
    task t_abort;
        wr(`FCSR_REG_CTRL, 32'h0000_0000);
        rd(`FCSR_REG_CTRL);
        `CHK(rv[1:0], 2'b00)
        fault <= 8'h10;
        cmd(8'h40, 1'b1, 8'hd0);
        repeat (4) @(posedge clk);
        rd(`FCSR_REG_STAT);
        `CHK(rv[1:0], 2'b01)
        wr(`FCSR_REG_CTRL, 32'h0000_0003);
        rd(`FCSR_REG_STAT);
        `CHK(rv[1:0], 2'b00)
        wait_idle;
        cmd(8'h70, 1'b0, 8'h00);
        rd(`FCSR_REG_OPST);
        `CHK(rv[7:0], 8'h80)
    endtask
    task t_unmapped;
        rd(4'hf);
        `CHK(rv, 32'h0000_0000)
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_boot;
        t_faults;
        t_flash_reset;
        t_abort;
        t_unmapped;
        wrap_up;
    end
    initial begin
        #1000000;
        err_total++;
        wrap_up;
    end
endmodule // tb_top
bind fcsr_host fcsr_checker #(.RESET_PULSE_CYC(RESET_PULSE_CYC)) u_chk (.clk(clk), .rst(rst),
    .reset_powerdown_n_q(reset_powerdown_n_q), .chip_select_combo_n_q(chip_select_combo_n_q),
    .oe_n_q(oe_n_q), .we_n_q(we_n_q), .dq_out_q(dq_out_q), .dq_oe_q(dq_oe_q));
